// ===== host_model.sv
// Host model issuing single-byte register accesses
`timescale 1ns/100ps
module host_model (
	input wire logic i_sys_clk,
	output test_port_pkg::reg_req_t o_req,
	input wire test_port_pkg::reg_rsp_t i_rsp
);
	import test_port_pkg::*;

	initial o_req = '0;

	// Strobe held across exactly one sampling edge
	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_sys_clk);
		#1;
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_sys_clk);
		#1;
		o_req = '0;
	endtask

	// Data taken while the one-cycle answer stands
	task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_sys_clk);
		#1;
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_sys_clk);
		#1;
		d = i_rsp.valid ? i_rsp.data : 'x;
		o_req = '0;
	endtask
endmodule

// ===== pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int unsigned WIDTH = 6
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Asynchronous inputs
	input wire logic [WIDTH-1:0] i_async,
	// Synchronised outputs
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage_one <= '0;
			o_sync <= '0;
		end else begin
			stage_one <= i_async;
			o_sync <= stage_one;
		end
	end

endmodule

// ===== test_port_pkg.sv
// Constants and carrier types for the test port and self-check register set
package test_port_pkg;

	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PIN_COUNT = 6;
	localparam int unsigned PROBE_SEL_W = 5;
	localparam int unsigned PROBE_GROUPS = 32;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_DRIVE_ENABLE = 6'h33;
	localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = 6'h34;
	localparam logic [ADDR_W-1:0] ADDR_PROBE_READBACK = 6'h35;
	localparam logic [ADDR_W-1:0] ADDR_SELF_CHECK = 6'h36;
	localparam logic [ADDR_W-1:0] ADDR_REVISION = 6'h37;

	// Values after reset
	localparam logic [DATA_W-1:0] RESET_DRIVE_ENABLE = 8'h80;
	localparam logic [DATA_W-1:0] RESET_PIN_LEVEL = 8'h00;
	localparam logic [DATA_W-1:0] RESET_SELF_CHECK = 8'h40;
	localparam logic [DATA_W-1:0] RESET_PROBE_VALUE = 8'h00;
	localparam logic [PIN_COUNT-1:0] RESET_PINS = 6'h00;

	// Field positions
	localparam int unsigned PIN_FIELD_LO = 1;
	localparam int unsigned PIN_FIELD_HI = 6;
	localparam int unsigned IO_SELECT_BIT = 7;
	localparam int unsigned NONLINEAR_BIT = 6;
	localparam int unsigned PROD_HIGH_BIT = 7;
	localparam int unsigned PROD_LOW_HI = 5;
	localparam int unsigned PROD_LOW_LO = 4;
	localparam int unsigned SELF_SEL_HI = 3;
	localparam int unsigned SELF_SEL_LO = 0;

	// Self check selector codes
	localparam logic [3:0] SELF_CHECK_ON = 4'h9;
	localparam logic [3:0] SELF_CHECK_OFF = 4'h0;

	// Arbitrary neutral revision code
	localparam logic [DATA_W-1:0] DEFAULT_REVISION = 8'h5A;

	typedef logic [PIN_COUNT-1:0] pin_vec_t;
	typedef logic [PROBE_GROUPS-1:0][DATA_W-1:0] probe_groups_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} reg_rsp_t;

endpackage

// ===== test_port_self_check_select_regs.sv
// Test port, probe bus readback, self-check control and revision registers
//
// Function
// RULE_01 - Drive enable bit n turns on the output driver of pin Dn.
// RULE_02 - With SPI host access, software uses only pins D1 to D4.
// RULE_03 - With UART and line driver enabled, software uses only D1 to D4.
// RULE_04 - I/O select bit 7 of pin level register makes port general I/O; the code drives stored levels only while i_serial_host_active is high.
// RULE_05 - In I/O mode enabled pins are outputs, all others are inputs.
// RULE_06 - In I/O mode enabled pins drive their stored level bit.
// RULE_07 - Pin level read in I/O mode returns live pin states D6..D1.
// RULE_08 - Pin level read with I/O select clear returns stored contents.
// RULE_09 - Read-only register shows current eight-bit internal probe bus.
// RULE_10 - Probe readback presents the bus chosen by the probe selector.
// RULE_11 - Non-linear receive bit makes receiver processing non-linear at 106 kBd.
// RULE_12 - Under non-linear receive, thresholds act non-linearly too.
// RULE_13 - Self check select value 1001b enables the digital self test.
// RULE_14 - Software writes 0000b to self check select for normal operation.
// RULE_15 - CRC compute command starts self test while self test enabled.
// RULE_16 - Read-only revision register returns a fixed design code.
// RULE_17 - Software treats drive enable bits 7,0 and level bit 0 reserved.
// RULE_18 - Software leaves production bits 7 and 5..4 untouched.
// RULE_19 - Five-bit probe selector picks the group shown on the probe bus.
// RULE_20 - Reserved bits ignore writes and read zero unless production; drive enable bit 7 reads one here.
`timescale 1ns/100ps
module test_port_self_check_select_regs #(
	parameter logic [7:0] REVISION_CODE = test_port_pkg::DEFAULT_REVISION
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Host register port
	input wire test_port_pkg::reg_req_t i_reg_req,
	output test_port_pkg::reg_rsp_t o_reg_rsp,
	// Host interface status
	input wire logic i_serial_host_active,
	// Internal probe bus
	input wire test_port_pkg::probe_groups_t i_probe_groups,
	input wire logic [test_port_pkg::PROBE_SEL_W-1:0] i_probe_bus_selector,
	// Test port pins D1..D6
	input wire test_port_pkg::pin_vec_t i_pin_in,
	output test_port_pkg::pin_vec_t o_pin_out,
	output test_port_pkg::pin_vec_t o_pin_oe,
	// Receiver and self check controls
	input wire logic i_crc_compute_command,
	output logic o_nonlinear_receive,
	output logic o_self_check_enable,
	output logic o_self_check_start,
	output logic [2:0] o_production_bits
);

	import test_port_pkg::*;

	// Stored fields
	pin_vec_t pin_drive_enable_field;
	pin_vec_t pin_level_field;
	logic port_io_select;
	logic nonlinear_receive;
	logic [3:0] self_check_select;
	logic [2:0] production_bits;
	logic [DATA_W-1:0] probe_bus_value;
	pin_vec_t pin_seen;

	// Address decode
	wire logic hit_drive = i_reg_req.addr == ADDR_DRIVE_ENABLE;
	wire logic hit_level = i_reg_req.addr == ADDR_PIN_LEVEL;
	wire logic hit_probe = i_reg_req.addr == ADDR_PROBE_READBACK;
	wire logic hit_self = i_reg_req.addr == ADDR_SELF_CHECK;
	wire logic hit_rev = i_reg_req.addr == ADDR_REVISION;
	wire logic wr_drive = i_reg_req.wr && hit_drive;
	wire logic wr_level = i_reg_req.wr && hit_level;
	wire logic wr_self = i_reg_req.wr && hit_self;
	wire logic [DATA_W-1:0] wdata = i_reg_req.wdata;

	// Mode and pin function
	wire logic io_active = port_io_select && i_serial_host_active; // RULE_04
	wire logic [DATA_W-1:0] probe_mux = i_probe_groups[i_probe_bus_selector]; // RULE_19
	wire pin_vec_t test_drive = probe_bus_value[PIN_COUNT-1:0];
	wire pin_vec_t next_pin_out = io_active ? pin_level_field : test_drive; // RULE_06
	wire pin_vec_t next_pin_oe = pin_drive_enable_field; // RULE_05
	wire logic self_check_on = self_check_select == SELF_CHECK_ON; // RULE_13
	wire logic next_self_check_start = i_crc_compute_command && self_check_on; // RULE_15

	// Read images
	wire logic [DATA_W-1:0] drive_image = {1'b1, pin_drive_enable_field, 1'b0}; // RULE_20
	wire pin_vec_t level_bits = port_io_select ? pin_seen : pin_level_field; // RULE_07
	wire logic [DATA_W-1:0] level_image = {port_io_select, level_bits, 1'b0}; // RULE_08
	wire logic [DATA_W-1:0] self_image = {production_bits[2], nonlinear_receive,
		production_bits[1:0], self_check_select};
	wire logic [DATA_W-1:0] next_rdata =
		hit_drive ? drive_image :
		hit_level ? level_image :
		hit_probe ? probe_bus_value : // RULE_09
		hit_self ? self_image :
		hit_rev ? REVISION_CODE : // RULE_16
		8'h00;

	// Pin inputs cross into the clock domain
	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_pin_in),
		.o_sync(pin_seen)
	);

	// Test port registers; reserved bits are dropped on write
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_drive_enable_field <= RESET_DRIVE_ENABLE[PIN_FIELD_HI:PIN_FIELD_LO];
			pin_level_field <= RESET_PIN_LEVEL[PIN_FIELD_HI:PIN_FIELD_LO];
			port_io_select <= RESET_PIN_LEVEL[IO_SELECT_BIT];
		end else begin
			if (wr_drive) begin
				pin_drive_enable_field <= wdata[PIN_FIELD_HI:PIN_FIELD_LO]; // RULE_01
			end
			if (wr_level) begin
				pin_level_field <= wdata[PIN_FIELD_HI:PIN_FIELD_LO];
				port_io_select <= wdata[IO_SELECT_BIT]; // RULE_04
			end
		end
	end

	// Self check control register
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			nonlinear_receive <= RESET_SELF_CHECK[NONLINEAR_BIT];
			self_check_select <= RESET_SELF_CHECK[SELF_SEL_HI:SELF_SEL_LO];
			production_bits <= {RESET_SELF_CHECK[PROD_HIGH_BIT],
				RESET_SELF_CHECK[PROD_LOW_HI:PROD_LOW_LO]};
		end else if (wr_self) begin
			nonlinear_receive <= wdata[NONLINEAR_BIT]; // RULE_11
			self_check_select <= wdata[SELF_SEL_HI:SELF_SEL_LO]; // RULE_13
			production_bits <= {wdata[PROD_HIGH_BIT], wdata[PROD_LOW_HI:PROD_LOW_LO]};
		end
	end

	// Probe bus capture
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			probe_bus_value <= RESET_PROBE_VALUE;
		end else begin
			probe_bus_value <= probe_mux; // RULE_10
		end
	end

	// Registered outputs
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pin_out <= RESET_PINS;
			o_pin_oe <= RESET_PINS;
			o_nonlinear_receive <= RESET_SELF_CHECK[NONLINEAR_BIT];
			o_self_check_enable <= 1'b0;
			o_self_check_start <= 1'b0;
			o_production_bits <= 3'h0;
			o_reg_rsp <= '0;
		end else begin
			o_pin_out <= next_pin_out; // RULE_06
			o_pin_oe <= next_pin_oe; // RULE_01
			o_nonlinear_receive <= nonlinear_receive; // RULE_12
			o_self_check_enable <= self_check_on; // RULE_13
			o_self_check_start <= next_self_check_start; // RULE_15
			o_production_bits <= production_bits;
			o_reg_rsp.valid <= i_reg_req.rd;
			o_reg_rsp.data <= i_reg_req.rd ? next_rdata : 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);

	drive_enable_pins_a: assert property (wr_drive |=> ##1 // RULE_01
		o_pin_oe == $past(wdata[PIN_FIELD_HI:PIN_FIELD_LO], 2))
		else $error("pin enables do not follow drive enable write");

	io_drive_level_a: assert property (wr_level && wdata[IO_SELECT_BIT] // RULE_06
		&& i_serial_host_active ##1 i_serial_host_active |=>
		o_pin_out == $past(wdata[PIN_FIELD_HI:PIN_FIELD_LO], 2))
		else $error("io mode pins do not drive stored level");

	test_drive_probe_a: assert property (!port_io_select |=> // RULE_04
		o_pin_out == $past(probe_bus_value[PIN_COUNT-1:0]))
		else $error("test mode pins do not carry probe bus");

	readback_pins_a: assert property (i_reg_req.rd && hit_level && port_io_select // RULE_07
		|=> o_reg_rsp.valid && o_reg_rsp.data[PIN_FIELD_HI:PIN_FIELD_LO] == $past(pin_seen))
		else $error("io mode read does not show pin states");

	readback_store_a: assert property (i_reg_req.rd && hit_level && !port_io_select // RULE_08
		|=> o_reg_rsp.data == {1'b0, $past(pin_level_field), 1'b0})
		else $error("stored level not read back");

	probe_select_a: assert property (i_reg_req.rd && hit_probe ##0 // RULE_10
		($stable(i_probe_bus_selector) && $past(i_reset_n)) [*1] |=>
		o_reg_rsp.data == $past(i_probe_groups[i_probe_bus_selector], 2))
		else $error("probe readback does not match selected group");

	nonlinear_ctrl_a: assert property (wr_self |=> ##1 // RULE_11
		o_nonlinear_receive == $past(wdata[NONLINEAR_BIT], 2))
		else $error("non-linear receive does not follow write");

	self_enable_a: assert property (wr_self && wdata[SELF_SEL_HI:SELF_SEL_LO] == 4'h9 // RULE_13
		##1 !wr_self |=> o_self_check_enable)
		else $error("self check not enabled by 1001b");

	self_start_a: assert property (i_crc_compute_command && self_check_on // RULE_15
		|=> o_self_check_start ##1 ($past(i_crc_compute_command) || !o_self_check_start))
		else $error("self test start missing or stretched");

	no_start_off_a: assert property (!self_check_on |=> !o_self_check_start) // RULE_15
		else $error("self test started while disabled");

	revision_read_a: assert property (i_reg_req.rd && hit_rev // RULE_16
		|=> o_reg_rsp.data == REVISION_CODE)
		else $error("revision register wrong");

	reserved_zero_a: assert property (i_reg_req.rd && hit_drive // RULE_20
		|=> o_reg_rsp.data[0] == 1'b0 && o_reg_rsp.data[7] == 1'b1)
		else $error("reserved drive enable bits read wrong");

	// Register port checks
	read_answer_a: assert property (i_reg_req.rd // RULE_09
		|=> o_reg_rsp.valid)
		else $error("read not answered in the next cycle");

	idle_quiet_a: assert property (!i_reg_req.rd // RULE_20
		|=> !o_reg_rsp.valid && o_reg_rsp.data == 8'h00)
		else $error("response present without a read");

	write_silent_a: assert property (i_reg_req.wr && !i_reg_req.rd // RULE_20
		|=> !o_reg_rsp.valid)
		else $error("write produced a read answer");

	unmapped_zero_a: assert property (i_reg_req.rd // RULE_20
		&& !(hit_drive || hit_level || hit_probe || hit_self || hit_rev)
		|=> o_reg_rsp.data == 8'h00)
		else $error("unmapped address does not read zero");

	level_reserved_a: assert property (i_reg_req.rd && hit_level // RULE_20
		|=> o_reg_rsp.data[0] == 1'b0)
		else $error("reserved pin level bit reads nonzero");

	enable_readback_a: assert property (i_reg_req.rd && hit_drive // RULE_01
		|=> o_reg_rsp.data[PIN_FIELD_HI:PIN_FIELD_LO] == $past(pin_drive_enable_field))
		else $error("drive enable field not read back");

	io_select_read_a: assert property (i_reg_req.rd && hit_level // RULE_04
		|=> o_reg_rsp.data[IO_SELECT_BIT] == $past(port_io_select))
		else $error("io select bit not read back");

	probe_readback_a: assert property (i_reg_req.rd && hit_probe // RULE_09
		|=> o_reg_rsp.data == $past(probe_bus_value))
		else $error("probe readback differs from captured bus");

	self_readback_a: assert property (i_reg_req.rd && hit_self // RULE_13
		|=> o_reg_rsp.data[SELF_SEL_HI:SELF_SEL_LO] == $past(self_check_select)
		&& o_reg_rsp.data[NONLINEAR_BIT] == $past(nonlinear_receive))
		else $error("self check register not read back");

	// Pin checks
	oe_hold_a: assert property (!wr_drive // RULE_05
		|=> ##1 $stable(o_pin_oe))
		else $error("pin directions changed without a write");

	level_store_a: assert property (wr_level // RULE_06
		|=> pin_level_field == $past(wdata[PIN_FIELD_HI:PIN_FIELD_LO]))
		else $error("pin level field does not take the write");

	io_level_out_a: assert property (io_active // RULE_06
		|=> o_pin_out == $past(pin_level_field))
		else $error("io mode pin levels differ from stored field");

	probe_capture_a: assert property ($stable(i_probe_bus_selector) // RULE_19
		|=> probe_bus_value == $past(i_probe_groups[i_probe_bus_selector]))
		else $error("probe capture misses the selected group");

	// Self check checks
	nonlinear_hold_a: assert property (!wr_self // RULE_12
		|=> ##1 $stable(o_nonlinear_receive))
		else $error("non-linear receive changed without a write");

	self_disable_a: assert property (wr_self // RULE_13
		&& wdata[SELF_SEL_HI:SELF_SEL_LO] != SELF_CHECK_ON ##1 !wr_self
		|=> !o_self_check_enable)
		else $error("self check still enabled after other select value");

	start_needs_cmd_a: assert property (!i_crc_compute_command // RULE_15
		|=> !o_self_check_start)
		else $error("self test started without a command");

	production_keep_a: assert property (wr_self |=> ##1 // RULE_20
		o_production_bits[2] == $past(wdata[PROD_HIGH_BIT], 2)
		&& o_production_bits[1:0] == $past(wdata[PROD_LOW_HI:PROD_LOW_LO], 2))
		else $error("production bits do not follow write");

	// Main scenarios
	io_mode_c: cover property (wr_level && wdata[IO_SELECT_BIT] ##2 io_active);
	io_out_c: cover property (io_active && pin_drive_enable_field != '0);
	self_start_c: cover property (o_self_check_enable ##1 o_self_check_start);
	pin_read_c: cover property (i_reg_req.rd && hit_level && port_io_select);
	probe_read_c: cover property (i_reg_req.rd && hit_probe);

endmodule

// ===== test_port_self_check_select_regs_tb.sv
// Self-checking bench for the test port and self-check registers
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_port_self_check_select_regs_tb;
	import test_port_pkg::*;
	logic i_sys_clk, i_reset_n, serial_act, crc_cmd, nonlin, sc_en, sc_start;
	reg_req_t req;
	reg_rsp_t rsp;
	probe_groups_t groups;
	logic [PROBE_SEL_W-1:0] sel;
	pin_vec_t pin_in, pin_ext, pin_out, pin_oe;
	// Enabled pins carry the level the block drives
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
	logic [2:0] prod;
	logic [DATA_W-1:0] rdata;
	int miscompares = 0, samples_checked = 0, seed = 12, i, v;
	int mdl[int];
	int grp[32];

	host_model u_host (.i_sys_clk(i_sys_clk), .o_req(req), .i_rsp(rsp));
	test_port_self_check_select_regs u_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_reg_req(req), .o_reg_rsp(rsp), .i_serial_host_active(serial_act),
		.i_probe_groups(groups), .i_probe_bus_selector(sel), .i_pin_in(pin_in),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_crc_compute_command(crc_cmd),
		.o_nonlinear_receive(nonlin), .o_self_check_enable(sc_en),
		.o_self_check_start(sc_start), .o_production_bits(prod));

	function automatic int exp_read(int a);
		case (a)
			'h33: return 'h80 | mdl['h33];
			'h34: return (mdl['h34] & 'h80) ? 'h80 | (int'(pin_in) << 1) : mdl['h34];
			'h35: return grp[sel];
			'h36: return mdl['h36];
			'h37: return 'h5A;
			default: return 0;
		endcase
	endfunction

	function automatic int exp_pins();
		if ((mdl['h34] & 'h80) && serial_act)
			return (mdl['h34] >> 1) & 'h3F;
		return grp[sel] & 'h3F;
	endfunction

	task automatic wr(int a, int d);
		u_host.reg_write(6'(a), 8'(d));
		case (a)
			'h33: mdl[a] = d & 'h7E;
			'h34: mdl[a] = d & 'hFE;
			'h36: mdl[a] = d & 'hFF;
			default: ;
		endcase
	endtask

	task automatic rd_chk(int a);
		u_host.reg_read(6'(a), rdata);
		`CHK(rdata, 8'(exp_read(a)))
	endtask

	task automatic crc_pulse(logic exp);
		crc_cmd = 1'b1;
		@(posedge i_sys_clk);
		#1;
		crc_cmd = 1'b0;
		`CHK(sc_start, exp)
		@(posedge i_sys_clk);
		#1;
		`CHK(sc_start, 1'b0)
	endtask

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	// Watchdog well beyond the few hundred cycles the run needs
	initial begin
		#200000;
		miscompares++;
		test_done;
	end

	initial begin
		i_reset_n = 1'b0;
		serial_act = 1'b0;
		crc_cmd = 1'b0;
		sel = '0;
		pin_ext = '0;
		for (i = 0; i < 32; i++) begin
			grp[i] = $random(seed) & 'hFF;
			groups[i] = 8'(grp[i]);
		end
		mdl['h33] = 0;
		mdl['h34] = 0;
		mdl['h36] = 'h40;
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_reset_n = 1'b1;
		`CHK(nonlin, 1'b1)
		for (i = 'h32; i <= 'h38; i++) rd_chk(i);
		// Read-only and unmapped places refuse writes
		wr('h35, 'hFF);
		wr('h37, 'hFF);
		wr('h38, 'h55);
		for (i = 'h32; i <= 'h38; i++) rd_chk(i);
		for (i = 0; i < 12; i++) begin
			serial_act = i[0];
			v = $random(seed);
			wr('h33, serial_act ? v & 'h1E : v);
			wr('h34, $random(seed) & 'hFE);
			pin_ext = 6'($random(seed));
			sel = 5'($random(seed));
			repeat (3) @(posedge i_sys_clk);
			#1;
			`CHK(pin_oe, 6'(mdl['h33] >> 1))
			`CHK(pin_out, 6'(exp_pins()))
			rd_chk('h33);
			rd_chk('h34);
			rd_chk('h35);
		end
		wr('h36, 'h49);
		@(posedge i_sys_clk);
		#1;
		`CHK(sc_en, 1'b1)
		`CHK(nonlin, 1'b1)
		`CHK(prod, 3'b000)
		crc_pulse(1'b1);
		wr('h36, 'h00);
		@(posedge i_sys_clk);
		#1;
		`CHK(sc_en, 1'b0)
		`CHK(nonlin, 1'b0)
		crc_pulse(1'b0);
		rd_chk('h36);
		test_done;
	end
endmodule
